// ### include/ddr2_cmd_pkg.sv
// Purpose: shared constants and types for the command legality link
// Assumes: 40 MHz clock, 25 ns period
// Notes:   least times in ps, rounded up to whole cycles; refresh interval in ns, rounded down
package ddr2_cmd_pkg;
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned BANKS         = 4;
	localparam int unsigned BANK_W        = 2;
	localparam int unsigned ADDR_W        = 14;
	// least times, rounded up to whole cycles
	localparam int unsigned WRITE_RECOVERY_TIME_PS = 15000;
	localparam int unsigned ROW_CYCLE_TIME_PS      = 55000;
	localparam int unsigned MODE_SET_DELAY_PS      = 50000;
	localparam int unsigned WR_CYC  = (WRITE_RECOVERY_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RC_CYC  = (ROW_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned MRD_CYC = (MODE_SET_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CNT_W   = 4;
	// refresh interval in hot case range, ns
	localparam int unsigned AVERAGE_REFRESH_INTERVAL_NS = 7800;
	localparam int unsigned REFI_CYC = AVERAGE_REFRESH_INTERVAL_NS * 1000 / CLK_PERIOD_PS;
	localparam int unsigned REFI_W   = 10;
	localparam int unsigned HOT_SR_BIT = 7;
	localparam logic [1:0] SECOND_EXT_MODE_BA = 2'h2;
	localparam int unsigned AP_BIT = 10;
	typedef enum logic [3:0] {
		CMD_DESELECT  = 4'h0,
		CMD_NOP       = 4'h1,
		CMD_READ      = 4'h2,
		CMD_WRITE     = 4'h3,
		CMD_ACTIVATE  = 4'h4,
		CMD_PRECHARGE = 4'h5,
		CMD_REFRESH   = 4'h6,
		CMD_MODE_SET  = 4'h7
	} cmd_t;
	typedef enum logic [2:0] {
		BANK_IDLE   = 3'h0,
		BANK_ACTIVE = 3'h1,
		BANK_WR_REC = 3'h2,
		BANK_WR_AP  = 3'h3,
		BANK_PRECH  = 3'h4
	} bank_state_t;
	typedef enum logic [1:0] {
		DEV_NORMAL  = 2'h0,
		DEV_REFRESH = 2'h1,
		DEV_MODE    = 2'h2
	} dev_state_t;
	// plain pin decode: cs, ras, cas, we
	function automatic cmd_t decode_cmd(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		cmd_t c;
		c = CMD_DESELECT;
		if (!cs_n)
		begin
			case ({ras_n, cas_n, we_n})
				3'h7: c = CMD_NOP;
				3'h5: c = CMD_READ;
				3'h4: c = CMD_WRITE;
				3'h3: c = CMD_ACTIVATE;
				3'h2: c = CMD_PRECHARGE;
				3'h1: c = CMD_REFRESH;
				default: c = CMD_MODE_SET;
			endcase
		end
		return c;
	endfunction
endpackage

// ### include/ddr2_cmd_if.sv
// Purpose: command bus between controller and device end
// Assumes: one clock, commands sampled on each rising edge
// Notes:   controller drives all signals
`timescale 1ns/1ps
interface ddr2_cmd_if
	import ddr2_cmd_pkg::*;
();
	logic              cs_n;
	logic              ras_n;
	logic              cas_n;
	logic              we_n;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] addr;
	modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, addr);
	modport dev  (input  cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// ### verilog/ddr2_legality_dev.sv
// Purpose: device end tracking bank and device states, flagging illegal commands
// Assumes: commands arrive from same-clock controller logic
// Notes:   illegal commands are ignored and reported; state is left intact
`timescale 1ns/1ps
module ddr2_legality_dev
	import ddr2_cmd_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	ddr2_cmd_if.dev                bus,
	output logic                   o_illegal,
	output logic [3:0]             o_illegal_cmd,
	output logic [BANK_W-1:0]      o_illegal_bank,
	output logic [15:0]            o_illegal_count,
	output logic [BANKS-1:0]       o_bank_idle,
	output logic                   o_dev_busy,
	output logic                   o_hot_self_refresh
);
	////////////////////////////////////////////////////////////////////////
	bank_state_t            bank_st [BANKS];
	bank_state_t            next_bank_st [BANKS];
	logic [CNT_W-1:0]       bank_cnt [BANKS];
	logic [CNT_W-1:0]       next_bank_cnt [BANKS];
	dev_state_t             dev_st;
	dev_state_t             next_dev_st;
	logic [CNT_W-1:0]       dev_cnt;
	logic [CNT_W-1:0]       next_dev_cnt;
	logic                   next_illegal;
	logic [15:0]            next_illegal_count;
	logic [BANKS-1:0]       next_bank_idle;
	logic                   next_hot;
	cmd_t                   cmd;
	logic                   all_idle;
	logic                   bad;

	always_comb
	begin
		cmd = decode_cmd(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n);
		all_idle = 1'b1;
		for (int b = 0; b < BANKS; b++)
		begin
			if (bank_st[b] != BANK_IDLE)
				all_idle = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_dev_st  = dev_st;
		next_dev_cnt = dev_cnt;
		next_hot     = o_hot_self_refresh;
		bad          = 1'b0;
		for (int b = 0; b < BANKS; b++)
		begin
			next_bank_st[b]  = bank_st[b];
			next_bank_cnt[b] = (bank_cnt[b] != '0) ? bank_cnt[b] - 1'b1 : bank_cnt[b];
		end
		if (dev_st != DEV_NORMAL)
		begin
			if (dev_cnt != '0)
				next_dev_cnt = dev_cnt - 1'b1;
			else
				next_dev_st = DEV_NORMAL;
			if (cmd != CMD_DESELECT && cmd != CMD_NOP)
				bad = 1'b1;
		end
		else
		begin
			// timed exits of each bank
			for (int b = 0; b < BANKS; b++)
			begin
				if (bank_cnt[b] == '0)
				begin
					if (bank_st[b] == BANK_WR_REC)
						next_bank_st[b] = BANK_ACTIVE;
					else if (bank_st[b] == BANK_WR_AP)
						next_bank_st[b] = BANK_PRECH;
					else if (bank_st[b] == BANK_PRECH)
						next_bank_st[b] = BANK_IDLE;
				end
			end
			case (cmd)
				CMD_REFRESH, CMD_MODE_SET:
				begin
					if (!all_idle)
						bad = 1'b1;
					else if (cmd == CMD_REFRESH)
					begin
						next_dev_st  = DEV_REFRESH;
						next_dev_cnt = CNT_W'(RC_CYC - 1);
					end
					else
					begin
						next_dev_st  = DEV_MODE;
						next_dev_cnt = CNT_W'(MRD_CYC - 1);
						if (bus.ba == SECOND_EXT_MODE_BA)
							next_hot = bus.addr[HOT_SR_BIT];
					end
				end
				CMD_ACTIVATE:
				begin
					if (bank_st[bus.ba] != BANK_IDLE)
						bad = 1'b1;
					else
						next_bank_st[bus.ba] = BANK_ACTIVE;
				end
				CMD_READ:
				begin
					if (bank_st[bus.ba] != BANK_ACTIVE)
						bad = 1'b1;
					else if (bus.addr[AP_BIT])
					begin
						next_bank_st[bus.ba]  = BANK_PRECH;
						next_bank_cnt[bus.ba] = CNT_W'(WR_CYC - 1);
					end
				end
				CMD_WRITE:
				begin
					if (bank_st[bus.ba] != BANK_ACTIVE && bank_st[bus.ba] != BANK_WR_REC)
						bad = 1'b1;
					else
					begin
						// a new write restarts recovery
						next_bank_st[bus.ba]  = bus.addr[AP_BIT] ? BANK_WR_AP : BANK_WR_REC;
						next_bank_cnt[bus.ba] = CNT_W'(WR_CYC - 1);
					end
				end
				CMD_PRECHARGE:
				begin
					for (int b = 0; b < BANKS; b++)
					begin
						if ((bus.addr[AP_BIT] || bus.ba == BANK_W'(b)) &&
							(bank_st[b] == BANK_WR_REC || bank_st[b] == BANK_WR_AP))
							bad = 1'b1;
					end
					// all or nothing: an illegal precharge closes no bank,
					// while timed exits of every bank still go ahead
					for (int b = 0; b < BANKS; b++)
					begin
						if (!bad && (bus.addr[AP_BIT] || bus.ba == BANK_W'(b)) &&
							bank_st[b] == BANK_ACTIVE)
						begin
							next_bank_st[b]  = BANK_PRECH;
							next_bank_cnt[b] = CNT_W'(WR_CYC - 1);
						end
					end
				end
				default:
				begin
				end
			endcase
		end
		next_illegal       = bad;
		next_illegal_count = (bad && o_illegal_count != 16'hffff) ?
			o_illegal_count + 16'h0001 : o_illegal_count;
		for (int b = 0; b < BANKS; b++)
			next_bank_idle[b] = (next_bank_st[b] == BANK_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			for (int b = 0; b < BANKS; b++)
			begin
				bank_st[b]  <= BANK_IDLE;
				bank_cnt[b] <= '0;
			end
			dev_st             <= DEV_NORMAL;
			dev_cnt            <= '0;
			o_illegal          <= 1'b0;
			o_illegal_cmd      <= 4'h0;
			o_illegal_bank     <= '0;
			o_illegal_count    <= 16'h0000;
			o_bank_idle        <= '1;
			o_dev_busy         <= 1'b0;
			o_hot_self_refresh <= 1'b0;
		end
		else
		begin
			bank_st            <= next_bank_st;
			bank_cnt           <= next_bank_cnt;
			dev_st             <= next_dev_st;
			dev_cnt            <= next_dev_cnt;
			o_illegal          <= next_illegal;
			o_illegal_cmd      <= next_illegal ? 4'(cmd) : o_illegal_cmd;
			o_illegal_bank     <= next_illegal ? bus.ba : o_illegal_bank;
			o_illegal_count    <= next_illegal_count;
			o_bank_idle        <= next_bank_idle;
			o_dev_busy         <= (next_dev_st != DEV_NORMAL);
			o_hot_self_refresh <= next_hot;
		end
	end
endmodule

// ### verilog/ddr2_legality_ctrl.sv
// Purpose: controller end issuing legal commands from a user request port
// Assumes: one request at a time, user waits for o_done
// Notes:   keeps no bank states, the caller tracks them; refresh pacing doubles when hot
`timescale 1ns/1ps
module ddr2_legality_ctrl
	import ddr2_cmd_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_req,
	input  wire logic [3:0]        i_cmd,
	input  wire logic [BANK_W-1:0] i_ba,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic              i_hot,
	ddr2_cmd_if.ctrl               bus,
	output logic                   o_done,
	output logic                   o_refresh_due
);
	////////////////////////////////////////////////////////////////////////
	logic [CNT_W-1:0]  wait_cnt;
	logic [CNT_W-1:0]  next_wait_cnt;
	logic [REFI_W-1:0] refi_cnt;
	logic [REFI_W-1:0] next_refi_cnt;
	logic [REFI_W-1:0] refi_lim;
	logic              next_refresh_due;
	logic [3:0]        pins;
	logic [3:0]        next_pins;
	logic [BANK_W-1:0] next_ba;
	logic [ADDR_W-1:0] next_addr;
	logic              next_done;
	cmd_t              want;

	always_comb
	begin
		want          = cmd_t'(i_cmd);
		next_pins     = 4'hf;
		next_ba       = bus.ba;
		next_addr     = bus.addr;
		next_done     = 1'b0;
		next_wait_cnt = (wait_cnt != '0) ? wait_cnt - 1'b1 : wait_cnt;
		// hot case: 7.8 us period; cool case twice that
		// counting up lets a change of case take effect at once, from reset too
		refi_lim      = i_hot ? REFI_W'(REFI_CYC - 1) : REFI_W'(REFI_CYC * 2 - 1);
		next_refi_cnt = (refi_cnt != '1) ? refi_cnt + 1'b1 : refi_cnt;
		next_refresh_due = o_refresh_due || (refi_cnt >= refi_lim);
		// caller must keep all banks idle for refresh and mode set, and bursts uninterrupted
		if (i_req && wait_cnt == '0 && !o_done)
		begin
			next_done = 1'b1;
			next_ba   = i_ba;
			next_addr = i_addr;
			case (want)
				CMD_READ:      next_pins = 4'h5;
				CMD_WRITE:     next_pins = 4'h4;
				CMD_ACTIVATE:  next_pins = 4'h3;
				CMD_PRECHARGE: next_pins = 4'h2;
				CMD_REFRESH:   next_pins = 4'h1;
				CMD_MODE_SET:  next_pins = 4'h0;
				CMD_NOP:       next_pins = 4'h7;
				default:       next_pins = 4'hf;
			endcase
			if (want == CMD_REFRESH)
			begin
				next_wait_cnt    = CNT_W'(RC_CYC);
				next_refresh_due = 1'b0;
				next_refi_cnt    = '0;
			end
			else if (want == CMD_MODE_SET)
				next_wait_cnt = CNT_W'(MRD_CYC);
			else if (want == CMD_WRITE)
				next_wait_cnt = CNT_W'(WR_CYC);
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			pins          <= 4'hf;
			bus.ba        <= '0;
			bus.addr      <= '0;
			o_done        <= 1'b0;
			wait_cnt      <= '0;
			refi_cnt      <= '0;
			o_refresh_due <= 1'b0;
		end
		else
		begin
			pins          <= next_pins;
			bus.ba        <= next_ba;
			bus.addr      <= next_addr;
			o_done        <= next_done;
			wait_cnt      <= next_wait_cnt;
			refi_cnt      <= next_refi_cnt;
			o_refresh_due <= next_refresh_due;
		end
	end

	assign bus.cs_n  = pins[3];
	assign bus.ras_n = pins[2];
	assign bus.cas_n = pins[1];
	assign bus.we_n  = pins[0];
endmodule

// ### tb/ddr2_legality_chk.sv
// Purpose: bus rules on the joined link
// Assumes: one clock domain
// Notes:   sees the interface and a few device outputs
`timescale 1ns/1ps
module ddr2_legality_chk
	import ddr2_cmd_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	input  wire logic [BANK_W-1:0] ba,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              o_illegal,
	input  wire logic [BANKS-1:0]  o_bank_idle,
	input  wire logic              o_hot_self_refresh
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);
	logic cmd;
	logic wr;
	logic rf;
	logic ms;
	assign cmd = !cs_n && !(ras_n && cas_n && we_n);
	assign wr  = cmd && ras_n && !cas_n && !we_n;
	assign rf  = cmd && !ras_n && !cas_n && we_n;
	assign ms  = cmd && !ras_n && !cas_n && !we_n;
	////////////////////////////////////////
	cmd_one_cycle_a: assert property (cmd |=> cs_n)
		else $error("command held over");
	wr_recovery_a: assert property
		(wr && !addr[AP_BIT] |=> !(cmd && !wr && ba == $past(ba)))
		else $error("bank used in write recovery");
	wr_autopre_a: assert property
		(wr && addr[AP_BIT] |=> !(cmd && ba == $past(ba)))
		else $error("bank used in auto precharge recovery");
	// row cycle ends before the third edge
	refresh_quiet_a: assert property (rf |=> !cmd [*2])
		else $error("command during refresh");
	mode_quiet_a: assert property (ms |=> !cmd)
		else $error("command during mode delay");
	idle_first_a: assert property (rf || ms |-> &o_bank_idle)
		else $error("refresh or mode set with open bank");
	no_illegal_a: assert property (!o_illegal)
		else $error("device flagged controller command");
	hot_flag_a: assert property
		(ms && ba == SECOND_EXT_MODE_BA |=> o_hot_self_refresh == $past(addr[HOT_SR_BIT]))
		else $error("hot self refresh flag wrong");
	cover property (rf ##1 !cmd);
	cover property (wr && addr[AP_BIT]);
	cover property (ms && ba == SECOND_EXT_MODE_BA && addr[HOT_SR_BIT]);
endmodule

// ### tb/tb_ddr2_state_command_legality.sv
// Purpose: joined ends plus a second device end driven directly
// Assumes: 40 MHz clock, inputs change 1 ns after the edge
// Notes:   only a direct driver can break the command rules
`timescale 1ns/1ps
module tb_ddr2_state_command_legality
	import ddr2_cmd_pkg::*;
;
	logic              i_clk = 0;
	logic              i_arst_n = 0;
	logic              i_req = 0;
	logic              i_hot = 1;
	logic [3:0]        i_cmd = 0;
	logic [BANK_W-1:0] i_ba = 0;
	logic [ADDR_W-1:0] i_addr = 0;
	logic              o_done;
	logic              o_refresh_due;
	logic              o_illegal;
	logic [15:0]       o_illegal_count;
	logic [BANKS-1:0]  o_bank_idle;
	logic              o_hot_self_refresh;
	logic              ill;
	logic [3:0]        bad_cmd;
	logic [BANK_W-1:0] bad_bank;
	logic [15:0]       cnt;
	logic [BANKS-1:0]  idle;
	logic              busy;
	int                checks = 0;
	int                fail_count = 0;
	int                cyc = 0;
	int                exp_cnt = 0;
	ddr2_cmd_if if0();
	ddr2_cmd_if if1();
	ddr2_legality_ctrl u_ddr2_legality_ctrl (.i_clk, .i_arst_n, .i_req, .i_cmd, .i_ba,
		.i_addr, .i_hot, .bus(if0.ctrl), .o_done, .o_refresh_due);
	ddr2_legality_dev u_ddr2_legality_dev (.i_clk, .i_arst_n, .bus(if0.dev), .o_illegal,
		.o_illegal_cmd(), .o_illegal_bank(), .o_illegal_count, .o_bank_idle,
		.o_dev_busy(), .o_hot_self_refresh);
	ddr2_legality_dev u_ddr2_legality_dev_b (.i_clk, .i_arst_n, .bus(if1.dev),
		.o_illegal(ill), .o_illegal_cmd(bad_cmd), .o_illegal_bank(bad_bank),
		.o_illegal_count(cnt), .o_bank_idle(idle), .o_dev_busy(busy), .o_hot_self_refresh());
	ddr2_legality_chk u_ddr2_legality_chk (.i_clk, .i_arst_n, .cs_n(if0.cs_n),
		.ras_n(if0.ras_n), .cas_n(if0.cas_n), .we_n(if0.we_n), .ba(if0.ba),
		.addr(if0.addr), .o_illegal, .o_bank_idle, .o_hot_self_refresh);
	always #12.5 i_clk = ~i_clk;
	////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			fail_count++;
			results();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick();
		@(posedge i_clk);
		#1;
	endtask
	// ras, cas, we pattern of a command code
	function automatic logic [2:0] pins(input logic [3:0] c);
		return (c >= 3) ? 3'(7 - c) : ((c == 2) ? 3'h5 : 3'h7);
	endfunction
	task automatic raw(input logic [3:0] c, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] a);
		if1.cs_n = (c == CMD_DESELECT);
		{if1.ras_n, if1.cas_n, if1.we_n} = pins(c);
		if1.ba = b;
		if1.addr = a;
		tick();
	endtask
	task automatic gap(input int n);
		repeat (n) raw(CMD_DESELECT, 0, 0);
	endtask
	task automatic try(input logic [3:0] c, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] a, input logic e);
		raw(c, b, a);
		check(ill, e);
		if (e)
		begin
			exp_cnt++;
			check(bad_cmd, c);
			check(bad_bank, b);
		end
		check(cnt, 16'(exp_cnt));
	endtask
	task automatic issue(input logic [3:0] c, input logic [BANK_W-1:0] b,
		input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		i_req = 1;
		i_cmd = c;
		i_ba = b;
		i_addr = a;
		while (o_done !== 1'b1 && n < 20)
		begin
			tick();
			n++;
		end
		check({if0.cs_n, if0.ras_n, if0.cas_n, if0.we_n}, {1'b0, pins(c)});
		check(if0.ba, b);
		i_req = 0;
		tick();
	endtask
	////////////////////////////////////////
	initial
	begin
		int n;
		logic [BANK_W-1:0] b;
		logic [ADDR_W-1:0] a;
		void'($urandom(1));
		raw(CMD_DESELECT, 0, 0);
		tick();
		i_arst_n = 1;
		check(if0.cs_n, 1'b1);
		check(o_bank_idle, 4'hf);
		n = 0;
		while (o_refresh_due !== 1'b1 && n < 700)
		begin
			tick();
			n++;
		end
		check(n > 156 && n <= 313, 1'b1);
		issue(CMD_REFRESH, 0, 0);
		// cool case: interval doubles
		i_hot = 0;
		n = 0;
		while (o_refresh_due !== 1'b1 && n < 1300)
		begin
			tick();
			n++;
		end
		check(n > 313 && n <= 626, 1'b1);
		i_hot = 1;
		issue(CMD_REFRESH, 0, 0);
		for (int v = 1; v >= 0; v--)
		begin
			issue(CMD_MODE_SET, SECOND_EXT_MODE_BA, 14'(v) << HOT_SR_BIT);
			gap(3);
			check(o_hot_self_refresh, v[0]);
		end
		for (int i = 0; i < 16; i++)
		begin
			b = BANK_W'($urandom);
			a = ADDR_W'($urandom);
			issue(CMD_ACTIVATE, b, a);
			issue(CMD_READ, b, a & 14'h3bff);
			issue(CMD_WRITE, b, a);
			if (!a[AP_BIT])
				issue(CMD_PRECHARGE, b, 14'h0);
			gap(8);
			check(o_bank_idle[b], 1'b1);
		end
		check(o_illegal_count, 16'h0);
		for (int c = CMD_READ; c <= CMD_MODE_SET; c++)
		begin
			b = BANK_W'($urandom);
			try(CMD_REFRESH, 0, 0, 0);
			check(busy, 1'b1);
			try(c, b, ADDR_W'($urandom), 1);
			gap(RC_CYC + 1);
			check(busy, 1'b0);
			try(CMD_MODE_SET, 0, 0, 0);
			check(busy, 1'b1);
			try(c, b, ADDR_W'($urandom), 1);
			gap(MRD_CYC + 1);
			check(busy, 1'b0);
		end
		try(CMD_ACTIVATE, 1, 0, 0);
		try(CMD_ACTIVATE, 2, 0, 0);
		try(CMD_WRITE, 1, 0, 0);
		try(CMD_WRITE, 1, 0, 0);
		try(CMD_READ, 2, 0, 0);
		try(CMD_WRITE, 1, 0, 0);
		try(CMD_READ, 1, 0, 1);
		gap(2);
		try(CMD_WRITE, 1, 14'h0400, 0);
		try(CMD_PRECHARGE, 1, 0, 1);
		gap(8);
		check(idle, 4'hb);
		try(CMD_ACTIVATE, 1, 0, 0);
		results();
	end
endmodule
